/* rtl/owt_defs.vh */
// Register indices, field positions and encodings of the one-shot wait timer
`ifndef OWT_DEFS_VH
`define OWT_DEFS_VH

// Register indices; byte address is four times the index
`define OWT_IDX_MODE      10'h120
`define OWT_IDX_CTL_ONE   10'h121
`define OWT_IDX_CTL_TWO   10'h122
`define OWT_IDX_STATUS    10'h123
`define OWT_IDX_IRQ_EN    10'h124
`define OWT_IDX_IRQ_CTL   10'h125
`define OWT_IDX_COUNT     10'h126
`define OWT_IDX_PERIOD    10'h128
`define OWT_IDX_CHANGE    10'h129
`define OWT_IDX_WAIT      10'h12a
`define OWT_IDX_BUFFER    10'h12b

// Mode register fields
`define OWT_MODE_START    0
`define OWT_MODE_BUF_C    2
`define OWT_MODE_BUF_D    3
`define OWT_MODE_PIN_EN   7

// Control one fields
`define OWT_C1_LVL_A      0
`define OWT_C1_LVL_B      1
`define OWT_C1_LVL_C      2
`define OWT_C1_LVL_D      3
`define OWT_C1_SRC_LO     4
`define OWT_C1_SRC_HI     6
`define OWT_C1_CLR        7

// Control two fields
`define OWT_C2_EDGE_LO    0
`define OWT_C2_EDGE_HI    1
`define OWT_C2_STOP       2

// Status and enable bits
`define OWT_ST_MATCH_A    0
`define OWT_ST_MATCH_B    1
`define OWT_ST_MATCH_C    2
`define OWT_ST_MATCH_D    3
`define OWT_ST_OVF        4
`define OWT_ST_WIDTH      5

// Interrupt control fields
`define OWT_IC_REQ        0
`define OWT_IC_LVL_LO     1
`define OWT_IC_LVL_HI     3

// Trigger edge encodings
`define OWT_EDGE_NONE     2'h0
`define OWT_EDGE_RISE     2'h1
`define OWT_EDGE_FALL     2'h2
`define OWT_EDGE_BOTH     2'h3

// Count source encodings
`define OWT_SRC_F1        3'h0
`define OWT_SRC_F2        3'h1
`define OWT_SRC_F4        3'h2
`define OWT_SRC_F8        3'h3
`define OWT_SRC_F32       3'h4
`define OWT_SRC_EXT       3'h5
`define OWT_SRC_OSC       3'h6

// Reset values and last divider count
`define OWT_RST_BYTE      8'h00
`define OWT_RST_WORD      16'h0000
`define OWT_DIV_LAST      5'h1f

`endif

/* rtl/owt_count_source.v */
// Count source selector producing one-cycle count enables
`timescale 1ns/1ps
`default_nettype none
`include "owt_defs.vh"

module owt_count_source
(
  input  wire       mclk,
  input  wire       srst,
  input  wire [2:0] srcSel,
  input  wire       extClockPin,
  input  wire       fastOscTick,
  output reg        countTick
);

  reg  [4:0] divCount;
  reg        extPrev;
  reg        next_tick;

  // Free-running divider shared by all internal rates
  always @(posedge mclk)
  begin
    if (srst)
    begin
      divCount <= 5'h00;
      extPrev  <= 1'b0;
    end
    else
    begin
      divCount <= divCount + 5'h01;
      extPrev  <= extClockPin;
    end
  end

  always @*
  begin
    case (srcSel)
      `OWT_SRC_F1:  next_tick = 1'b1;
      `OWT_SRC_F2:  next_tick = (divCount[0] == 1'b1);
      `OWT_SRC_F4:  next_tick = (divCount[1:0] == 2'h3);
      `OWT_SRC_F8:  next_tick = (divCount[2:0] == 3'h7);
      `OWT_SRC_F32: next_tick = (divCount == `OWT_DIV_LAST);
      `OWT_SRC_EXT: next_tick = extClockPin & ~extPrev;
      `OWT_SRC_OSC: next_tick = fastOscTick;
      default:      next_tick = 1'b0; // Forbidden code gives no count
    endcase
  end

  // Registered so the core sees a clean pulse
  always @(posedge mclk)
  begin
    if (srst)
      countTick <= 1'b0;
    else
      countTick <= next_tick;
  end

endmodule
`default_nettype wire

/* rtl/owt_timer.v */
// One-shot wait PWM timer with Avalon-MM register slave and combined interrupt
//
// Function
// - One waveform after wait; counter halts with output at stop-at-match.
// - Source field picks f1..f32, external rising edge, fast oscillator; 111 forbidden.
// - Counter steps per source tick; period is period value plus one.
// - Wait lasts wait value plus one; active width change minus wait.
// - No trigger edge or no stop-at-match: counting starts on start write.
// - Edge and stop-at-match selected with start set: counting begins on that trigger edge.
// - Start cleared stops count, output shows initial level, count held.
// - Stop-at-match: period match stops count, output initial, count held.
// - Four register matches and overflow share one interrupt request.
// - Pin A trigger input, pin B waveform output, C and D unused.
// - Counter register readable and writable by software.
// - Level select 0: idle low, high at wait, low at change.
// - Level select 1: idle high, low at wait, high at change.
// - Clear select 0 free runs; 1 clears at period match.
// - Writing control one drives initial level onto the pin.
// - Period, change point, wait registers; buffer always compared for match D, loaded into change point when buffered.
// - Buffer mode D: buffer holds next change point value.
// - Request set while any flag and its enable are both one.
// - Request drops when no enabled flag remains; nothing latched.
// - Flags not cleared by acknowledge; software clears them.
// - Free-running counter wraps after 65,536 counts.
`timescale 1ns/1ps
`default_nettype none
`include "owt_defs.vh"

module owt_timer
#(
  parameter CW = 16
)
(
  input  wire        mclk,
  input  wire        srst,
  input  wire [11:0] avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWriteData,
  output reg  [31:0] avsReadData,
  output reg         avsWaitRequest,
  input  wire        trigPin,
  input  wire        extClockPin,
  input  wire        fastOscTick,
  output reg         waveOut,
  output reg         waveOutDriveN,
  output reg         irqRequest,
  output reg  [2:0]  irqLevel,
  output reg         running
);

  // Register file
  reg  [7:0]              modeReg;
  reg  [7:0]              ctlOne;
  reg  [7:0]              ctlTwo;
  reg  [`OWT_ST_WIDTH-1:0] statusReg;
  reg  [`OWT_ST_WIDTH-1:0] irqEnable;
  reg  [CW-1:0]           countReg;
  reg  [CW-1:0]           periodReg;
  reg  [CW-1:0]           changeReg;
  reg  [CW-1:0]           waitReg;
  reg  [CW-1:0]           bufferReg;

  // Trigger synchroniser and edge detect
  reg                     trigMeta;
  reg                     trigSync;
  reg                     trigLast;
  reg                     armed;

  wire [9:0]              regIdx;
  wire                    wrTake;
  wire                    countTick;
  wire [1:0]              trigEdge;
  wire                    stopAtMatch;
  wire                    trigUsed;
  wire                    initLevel;
  wire                    trigHit;
  wire                    startSet;
  wire                    matchA;
  wire                    matchB;
  wire                    matchC;
  wire                    matchD;
  wire                    overflow;
  wire                    tickRun;
  wire [`OWT_ST_WIDTH-1:0] setEvents;
  reg  [31:0]             next_readData;

  // Zero-extend a narrow field to the data bus width
  function [31:0] owt_ext16;
    input [CW-1:0] val;
    begin
      owt_ext16 = {{(32-CW){1'b0}}, val};
    end
  endfunction

  // Match of the running count against one general register
  function owt_match;
    input [CW-1:0] cnt;
    input [CW-1:0] refVal;
    begin
      owt_match = (cnt == refVal);
    end
  endfunction

  assign regIdx      = avsAddress[11:2];
  // A write lands only at the edge where waitrequest is low
  assign wrTake      = avsWrite & ~avsWaitRequest;
  assign trigEdge    = {ctlTwo[`OWT_C2_EDGE_HI], ctlTwo[`OWT_C2_EDGE_LO]};
  assign stopAtMatch = ctlTwo[`OWT_C2_STOP];
  assign initLevel   = ctlOne[`OWT_C1_LVL_B];
  // Trigger only gates start when both fields ask for it
  assign trigUsed    = (trigEdge != `OWT_EDGE_NONE) & stopAtMatch;
  assign startSet    = modeReg[`OWT_MODE_START];

  owt_count_source u_src
  (
    .mclk        (mclk),
    .srst        (srst),
    .srcSel      (ctlOne[`OWT_C1_SRC_HI:`OWT_C1_SRC_LO]),
    .extClockPin (extClockPin),
    .fastOscTick (fastOscTick),
    .countTick   (countTick)
  );

  // Two-flop synchroniser, edge from stages two and three
  always @(posedge mclk)
  begin
    if (srst)
    begin
      trigMeta <= 1'b0;
      trigSync <= 1'b0;
      trigLast <= 1'b0;
    end
    else
    begin
      trigMeta <= trigPin;
      trigSync <= trigMeta;
      trigLast <= trigSync;
    end
  end

  // Edge kind chosen by the trigger field
  assign trigHit = ((trigEdge == `OWT_EDGE_RISE) & trigSync & ~trigLast) |
                   ((trigEdge == `OWT_EDGE_FALL) & ~trigSync & trigLast) |
                   ((trigEdge == `OWT_EDGE_BOTH) & (trigSync ^ trigLast));

  // Compare events, valid only on a counting tick
  assign tickRun  = running & countTick;
  assign matchA   = tickRun & owt_match(countReg, periodReg);
  assign matchB   = tickRun & owt_match(countReg, changeReg);
  assign matchC   = tickRun & owt_match(countReg, waitReg);
  assign matchD   = tickRun & owt_match(countReg, bufferReg);
  // Wrap at all ones of the counter
  assign overflow = tickRun & (&countReg);
  assign setEvents = {overflow, matchD, matchC, matchB, matchA};

  // Avalon slave handshake: one wait cycle, then waitrequest low for one edge
  always @(posedge mclk)
  begin
    if (srst)
    begin
      avsWaitRequest <= 1'b1;
      avsReadData    <= 32'h00000000;
    end
    else if (avsWaitRequest & (avsRead | avsWrite))
    begin
      avsWaitRequest <= 1'b0;
      avsReadData    <= next_readData;
    end
    else
    begin
      avsWaitRequest <= 1'b1;
    end
  end

  // Read mux; unmapped indices read as zero
  always @*
  begin
    next_readData = 32'h00000000;
    case (regIdx)
      `OWT_IDX_MODE:    next_readData = {24'h000000, modeReg};
      `OWT_IDX_CTL_ONE: next_readData = {24'h000000, ctlOne};
      `OWT_IDX_CTL_TWO: next_readData = {24'h000000, ctlTwo};
      `OWT_IDX_STATUS:  next_readData = {27'h0000000, statusReg};
      `OWT_IDX_IRQ_EN:  next_readData = {27'h0000000, irqEnable};
      // Request flag visible alongside the level
      `OWT_IDX_IRQ_CTL: next_readData = {28'h0000000, irqLevel, irqRequest};
      `OWT_IDX_COUNT:   next_readData = owt_ext16(countReg);
      `OWT_IDX_PERIOD:  next_readData = owt_ext16(periodReg);
      `OWT_IDX_CHANGE:  next_readData = owt_ext16(changeReg);
      `OWT_IDX_WAIT:    next_readData = owt_ext16(waitReg);
      `OWT_IDX_BUFFER:  next_readData = owt_ext16(bufferReg);
      default:          next_readData = 32'h00000000;
    endcase
  end

  // Plain configuration registers
  always @(posedge mclk)
  begin
    if (srst)
    begin
      ctlOne    <= `OWT_RST_BYTE;
      ctlTwo    <= `OWT_RST_BYTE;
      irqEnable <= {`OWT_ST_WIDTH{1'b0}};
      irqLevel  <= 3'h0;
      periodReg <= {CW{1'b1}};
      waitReg   <= `OWT_RST_WORD;
      bufferReg <= {CW{1'b1}};
    end
    else if (wrTake)
    begin
      // Level, source and clear bits belong to a stopped timer
      if (regIdx == `OWT_IDX_CTL_ONE)
        ctlOne <= avsWriteData[7:0];
      if (regIdx == `OWT_IDX_CTL_TWO)
        ctlTwo <= avsWriteData[7:0];
      if (regIdx == `OWT_IDX_IRQ_EN)
        irqEnable <= avsWriteData[`OWT_ST_WIDTH-1:0];
      if (regIdx == `OWT_IDX_IRQ_CTL)
        irqLevel <= avsWriteData[`OWT_IC_LVL_HI:`OWT_IC_LVL_LO];
      if (regIdx == `OWT_IDX_PERIOD)
        periodReg <= avsWriteData[CW-1:0];
      if (regIdx == `OWT_IDX_WAIT)
        waitReg <= avsWriteData[CW-1:0];
      if (regIdx == `OWT_IDX_BUFFER)
        bufferReg <= avsWriteData[CW-1:0];
    end
  end

  // Change point, refreshed from the buffer at period match in buffer mode
  always @(posedge mclk)
  begin
    if (srst)
      changeReg <= {CW{1'b1}};
    else if (matchA & modeReg[`OWT_MODE_BUF_D])
      // Buffered change point takes effect per period
      changeReg <= bufferReg;
    else if (wrTake & (regIdx == `OWT_IDX_CHANGE))
      changeReg <= avsWriteData[CW-1:0];
  end

  // Mode register holds start, buffer modes and pin enable
  always @(posedge mclk)
  begin
    if (srst)
      modeReg <= `OWT_RST_BYTE;
    else if (wrTake & (regIdx == `OWT_IDX_MODE))
      modeReg <= avsWriteData[7:0];
  end

  // Status flags: write zero clears, event in same cycle wins
  always @(posedge mclk)
  begin
    if (srst)
      statusReg <= {`OWT_ST_WIDTH{1'b0}};
    else if (wrTake & (regIdx == `OWT_IDX_STATUS))
      statusReg <= (statusReg & avsWriteData[`OWT_ST_WIDTH-1:0]) | setEvents;
    else
      statusReg <= statusReg | setEvents;
  end

  // Level request, follows flags and enables, never latched
  always @(posedge mclk)
  begin
    if (srst)
      irqRequest <= 1'b0;
    else
      irqRequest <= |(statusReg & irqEnable);
  end

  // Run control: start bit, trigger arming and stop at period match
  always @(posedge mclk)
  begin
    if (srst)
    begin
      running <= 1'b0;
      armed   <= 1'b0;
    end
    else if (wrTake & (regIdx == `OWT_IDX_MODE))
    begin
      // Start write begins counting when no trigger gating
      running <= avsWriteData[`OWT_MODE_START] & ~trigUsed;
      armed   <= avsWriteData[`OWT_MODE_START] & trigUsed;
    end
    else if (armed & trigHit)
    begin
      running <= 1'b1;
      armed   <= 1'b0;
    end
    else if (matchA & stopAtMatch)
    begin
      // Stop at period match, rearm if trigger gated
      running <= 1'b0;
      armed   <= startSet & trigUsed;
    end
  end

  // Counter; period-match clear beats a coincident software load
  always @(posedge mclk)
  begin
    if (srst)
      countReg <= `OWT_RST_WORD;
    else if (armed & trigHit & ~(wrTake & (regIdx == `OWT_IDX_MODE)))
      countReg <= `OWT_RST_WORD;
    else if (matchA & stopAtMatch)
      // Count held at the stop point
      countReg <= countReg;
    else if (matchA & ctlOne[`OWT_C1_CLR])
      countReg <= `OWT_RST_WORD;
    else if (wrTake & (regIdx == `OWT_IDX_COUNT))
      countReg <= avsWriteData[CW-1:0];
    else if (tickRun)
      // One step per source tick, wraps naturally
      countReg <= countReg + {{(CW-1){1'b0}}, 1'b1};
  end

  // Waveform pin; control one writes force the idle level
  always @(posedge mclk)
  begin
    if (srst)
      waveOut <= 1'b0;
    else if (wrTake & (regIdx == `OWT_IDX_CTL_ONE))
      // Initial level shows as soon as control one is written
      waveOut <= avsWriteData[`OWT_C1_LVL_B];
    else if (~running & ~armed)
      // Stopped timer shows the idle level
      waveOut <= initLevel;
    else if (matchA & stopAtMatch)
      // Output back to idle in the stopping cycle
      waveOut <= initLevel;
    else if (matchB)
      // Change point returns the idle level
      waveOut <= initLevel;
    else if (matchC)
      // Wait point drives the active level
      waveOut <= ~initLevel;
    else if (armed)
      waveOut <= initLevel;
  end

  // Pin B driven only once waveform output is enabled
  always @(posedge mclk)
  begin
    if (srst)
      waveOutDriveN <= 1'b1;
    else
      waveOutDriveN <= ~modeReg[`OWT_MODE_PIN_EN];
  end

endmodule
`default_nettype wire

/* tb/owt_timer_checker.sv */
// Port-level assertions for the one-shot wait timer
`timescale 1ns/1ps
`default_nettype none

module owt_timer_checker
(
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic [11:0] avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [31:0] avsReadData,
  input wire logic        avsWaitRequest,
  input wire logic        trigPin,
  input wire logic        extClockPin,
  input wire logic        fastOscTick,
  input wire logic        waveOut,
  input wire logic        waveOutDriveN,
  input wire logic        irqRequest,
  input wire logic [2:0]  irqLevel,
  input wire logic        running
);
  // One clock domain, so one clocking and one disable for all
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (srst);

  property p_wr_answer;
    $rose(avsRead || avsWrite) |=> !avsWaitRequest;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("no answer one cycle after request");
  property p_wr_one;
    !avsWaitRequest |=> avsWaitRequest;
  endproperty
  a_wr_one: assert property (p_wr_one) else $error("waitrequest low for more than one cycle");
  property p_wr_cause;
    !avsWaitRequest |-> $past(avsRead || avsWrite);
  endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("answer without a request");
  // Read data must not wander between accesses
  property p_rd_stand;
    avsWaitRequest && $past(avsWaitRequest) |-> $stable(avsReadData);
  endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read data changed while idle");
  // Pin only moves while counting or just after a register write
  property p_wave_cause;
    $changed(waveOut) |-> $past(running) || $past(avsWrite) || $past(avsWrite, 2);
  endproperty
  a_wave_cause: assert property (p_wave_cause) else $error("wave output moved while stopped");
  property p_drive_cause;
    $changed(waveOutDriveN) |-> $past(avsWrite) || $past(avsWrite, 2);
  endproperty
  a_drive_cause: assert property (p_drive_cause) else $error("pin drive changed without write");
  property p_level_cause;
    $changed(irqLevel) |-> $past(avsWrite) || $past(avsWrite, 2);
  endproperty
  a_level_cause: assert property (p_level_cause) else $error("interrupt level changed alone");
  // A request needs a fresh match while counting or a write
  property p_irq_rise;
    $rose(irqRequest) |-> $past(running, 2) || $past(avsWrite, 2) || $past(avsWrite, 3);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("request rose without a source");
  // Counting begins only on a start write or a recent trigger change
  property p_run_cause;
    $rose(running) |-> $past(avsWrite) || $past(avsWrite, 2) || ($past(trigPin) != $past(trigPin, 6));
  endproperty
  a_run_cause: assert property (p_run_cause) else $error("counter started without cause");
endmodule

bind owt_timer owt_timer_checker owt_timer_checker_inst
(
  .mclk           (mclk),
  .srst           (srst),
  .avsAddress     (avsAddress),
  .avsRead        (avsRead),
  .avsWrite       (avsWrite),
  .avsWriteData   (avsWriteData),
  .avsReadData    (avsReadData),
  .avsWaitRequest (avsWaitRequest),
  .trigPin        (trigPin),
  .extClockPin    (extClockPin),
  .fastOscTick    (fastOscTick),
  .waveOut        (waveOut),
  .waveOutDriveN  (waveOutDriveN),
  .irqRequest     (irqRequest),
  .irqLevel       (irqLevel),
  .running        (running)
);
`default_nettype wire

/* tb/owt_timer_bench.sv */
// Directed register-level bench for the one-shot wait timer
`timescale 1ns/1ps
`default_nettype none
`include "owt_defs.vh"

module owt_timer_bench;
  logic        mclk;
  logic        srst;
  logic [11:0] avsAddress;
  logic        avsRead;
  logic        avsWrite;
  logic [31:0] avsWriteData;
  logic [31:0] avsReadData;
  logic        avsWaitRequest;
  logic        trigPin;
  logic        extClockPin = 1'b0;
  logic [1:0]  extPhase = 2'h0;
  logic        fastOscTick = 1'b0;
  logic        waveOut;
  logic        waveOutDriveN;
  logic        irqRequest;
  logic [2:0]  irqLevel;
  logic        running;
  logic [31:0] q;
  logic [31:0] held;
  logic [31:0] modeBase;
  int          errors;
  int          checkCount;
  int          n;
  int          divs [7] = '{1, 2, 4, 8, 32, 4, 2};

  owt_timer owt_timer_inst
  (
    .mclk           (mclk),
    .srst           (srst),
    .avsAddress     (avsAddress),
    .avsRead        (avsRead),
    .avsWrite       (avsWrite),
    .avsWriteData   (avsWriteData),
    .avsReadData    (avsReadData),
    .avsWaitRequest (avsWaitRequest),
    .trigPin        (trigPin),
    .extClockPin    (extClockPin),
    .fastOscTick    (fastOscTick),
    .waveOut        (waveOut),
    .waveOutDriveN  (waveOutDriveN),
    .irqRequest     (irqRequest),
    .irqLevel       (irqLevel),
    .running        (running)
  );

  // Clock at 40 MHz
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // External count clock every four cycles, oscillator tick every other cycle
  always @(posedge mclk)
  begin
    extPhase <= extPhase + 2'h1;
    extClockPin <= extPhase[1];
    fastOscTick <= extPhase[0];
  end

  task automatic tally_and_finish;
    if (errors == 0 && checkCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    int k;
    k = 0;
    avsAddress <= {idx, 2'h0};
    avsWrite <= wr;
    avsRead <= ~wr;
    avsWriteData <= d;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (avsWaitRequest !== 1'b0 && k < 20);
    q = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    if (avsWaitRequest !== 1'b0)
    begin
      errors++;
      tally_and_finish();
    end
    @(posedge mclk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(q, exp);
  endtask

  // Bounded wait for a level; cycles spent come back in k
  task automatic till(input logic useRun, input logic v, output int k);
    k = 0;
    while ((useRun ? running : waveOut) !== v && k < 2000)
    begin
      @(posedge mclk);
      k++;
    end
    if (k >= 2000)
    begin
      errors++;
      tally_and_finish();
    end
  endtask

  // One shot with period 7, change 5, wait 2: active width is three ticks
  task automatic shot(input logic [2:0] src, input logic lvl, input logic [1:0] edg, input int div);
    // Level, source, clear set while stopped
    wr(`OWT_IDX_MODE, modeBase);
    trigPin <= 1'b0;
    wr(`OWT_IDX_CTL_ONE, {24'h0, 1'b1, src, 2'h0, lvl, 1'b0});
    chk(waveOut, lvl);
    chk(waveOutDriveN, 1'b0);
    wr(`OWT_IDX_CTL_TWO, {29'h0, 1'b1, edg});
    // A stop leaves the count at the period, so start again from zero
    wr(`OWT_IDX_COUNT, 32'h0);
    wr(`OWT_IDX_MODE, modeBase | 32'h1);
    if (edg != 2'h0)
    begin
      repeat (12) @(posedge mclk);
      chk(running, 1'b0);
      trigPin <= 1'b1;
      if (edg == 2'h2)
      begin
        repeat (5) @(posedge mclk);
        chk(running, 1'b0);
        trigPin <= 1'b0;
      end
      repeat (5) @(posedge mclk);
    end
    chk(running, 1'b1);
    till(1'b0, ~lvl, n);
    till(1'b0, lvl, n);
    chk(n, 3 * div);
    till(1'b1, 1'b0, n);
    chk(waveOut, lvl);
    rdc(`OWT_IDX_COUNT, 32'h7);
  endtask

  // Main sequence
  initial
  begin
    srst = 1'b1;
    avsAddress = 12'h0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWriteData = 32'h0;
    trigPin = 1'b0;
    modeBase = 32'h80;
    errors = 0;
    checkCount = 0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    chk({waveOutDriveN, running, irqRequest}, 32'h4);
    rdc(`OWT_IDX_PERIOD, 32'hffff);
    rdc(`OWT_IDX_WAIT, 32'h0);
    rdc(`OWT_IDX_CTL_ONE, 32'h0);
    wr(10'h127, 32'hff);
    rdc(10'h127, 32'h0);
    wr(`OWT_IDX_COUNT, 32'h1234);
    rdc(`OWT_IDX_COUNT, 32'h1234);
    wr(`OWT_IDX_PERIOD, 32'h7);
    wr(`OWT_IDX_CHANGE, 32'h5);
    wr(`OWT_IDX_WAIT, 32'h2);
    // Every source code except the forbidden 111, both idle levels
    for (int i = 0; i < 7; i++)
      shot(i[2:0], i[0], 2'h0, divs[i]);
    // Every trigger edge kind, divided by two for margin
    for (int e = 1; e < 4; e++)
      shot(3'h1, 1'b0, e[1:0], 2);
    // Buffered change point taken over at period match
    wr(`OWT_IDX_BUFFER, 32'h4);
    modeBase = 32'h88;
    shot(3'h0, 1'b0, 2'h0, 1);
    rdc(`OWT_IDX_CHANGE, 32'h4);
    // Stop by software in mid-pulse: change beyond the period keeps it active
    wr(`OWT_IDX_MODE, 32'h80);
    wr(`OWT_IDX_CHANGE, 32'h20);
    // Edge chosen but no stop-at-match, so the start write alone counts
    wr(`OWT_IDX_CTL_TWO, 32'h1);
    wr(`OWT_IDX_CTL_ONE, 32'h82);
    wr(`OWT_IDX_MODE, 32'h81);
    till(1'b0, 1'b0, n);
    wr(`OWT_IDX_MODE, 32'h80);
    // Idle level follows one cycle after the stop lands
    @(posedge mclk);
    chk({running, waveOut}, 32'h1);
    bus(1'b0, `OWT_IDX_COUNT, 32'h0);
    held = q;
    repeat (5) @(posedge mclk);
    rdc(`OWT_IDX_COUNT, held);
    // Free run through the top of the count
    wr(`OWT_IDX_CTL_ONE, 32'h0);
    wr(`OWT_IDX_STATUS, 32'h0);
    wr(`OWT_IDX_COUNT, 32'hfffe);
    wr(`OWT_IDX_MODE, 32'h81);
    repeat (4) @(posedge mclk);
    wr(`OWT_IDX_MODE, 32'h80);
    bus(1'b0, `OWT_IDX_STATUS, 32'h0);
    chk(q & 32'h10, 32'h10);
    // Combined request follows flag and enable, no latching
    wr(`OWT_IDX_IRQ_EN, 32'h10);
    repeat (3) @(posedge mclk);
    chk(irqRequest, 1'b1);
    wr(`OWT_IDX_IRQ_EN, 32'h0);
    repeat (3) @(posedge mclk);
    chk(irqRequest, 1'b0);
    wr(`OWT_IDX_IRQ_EN, 32'h10);
    repeat (3) @(posedge mclk);
    chk(irqRequest, 1'b1);
    wr(`OWT_IDX_STATUS, 32'h0);
    repeat (3) @(posedge mclk);
    chk(irqRequest, 1'b0);
    wr(`OWT_IDX_IRQ_CTL, 32'ha);
    chk(irqLevel, 3'h5);
    tally_and_finish();
  end
endmodule
`default_nettype wire
